// file: rtl/mmport_cfg.svh
`ifndef MMPORT_CFG_SVH
`define MMPORT_CFG_SVH

`define MMP_ADDR_W 13
`define MMP_DATA_W 8
`define MMP_OUT_PORT_OFS 13'h0000
`define MMP_IN_PORT_OFS 13'h0001
`define MMP_RAM_BASE 13'h0050
`define MMP_RAM_BYTES 176
`define MMP_PAGE_HI_LSB 8
`define MMP_OUT_PORT_RST 8'h00
`define MMP_RAM_RST 8'h00
`define MMP_UNMAPPED_RD 8'h00
`define MMP_BUS_DIV 2
`define MMP_CORE_PERIOD_NS 8
`define MMP_BUS_CYC_MAX_NS 500
`define MMP_BUS_CYC_MAX_CYC (`MMP_BUS_CYC_MAX_NS / `MMP_CORE_PERIOD_NS)

`endif

// file: rtl/mmport_pkg.sv
`include "mmport_cfg.svh"

package mmport_pkg;

    typedef enum logic {
        PH_FIRST = 1'b0,
        PH_SECOND = 1'b1
    } phase_t;

    typedef enum logic [1:0] {
        RGN_NONE = 2'h0,
        RGN_OUT = 2'h1,
        RGN_IN = 2'h3,
        RGN_RAM = 2'h2
    } region_t;

    typedef struct packed {
        phase_t phase;
        logic bus_clk;
        logic rd_ack;
        logic [`MMP_DATA_W-1:0] rdata;
    } top_state_t;

    typedef struct packed {
        logic [`MMP_RAM_BYTES-1:0][`MMP_DATA_W-1:0] mem;
    } ram_state_t;

    typedef struct packed {
        logic [`MMP_DATA_W-1:0] in_meta;
        logic [`MMP_DATA_W-1:0] in_sync;
        logic [`MMP_DATA_W-1:0] out_latch;
    } port_state_t;

endpackage : mmport_pkg

// file: rtl/cell_bus_if.sv
`include "mmport_cfg.svh"

interface cell_bus_if;
    logic [`MMP_DATA_W-1:0] wdata;
    logic [7:0] ram_idx;
    logic ram_wr;
    logic out_wr;
    logic [`MMP_DATA_W-1:0] ram_rdata;
    logic [`MMP_DATA_W-1:0] out_q;
    logic [`MMP_DATA_W-1:0] in_q;

    modport ctrl (
        output wdata, ram_idx, ram_wr, out_wr,
        input ram_rdata, out_q, in_q
    );
    modport ram (
        input wdata, ram_idx, ram_wr,
        output ram_rdata
    );
    modport port (
        input wdata, out_wr,
        output out_q, in_q
    );
endinterface : cell_bus_if

// file: rtl/ram_bank.sv
`include "mmport_cfg.svh"

module ram_bank (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    cell_bus_if.ram cb
);
    mmport_pkg::ram_state_t s_reg;
    mmport_pkg::ram_state_t s_next;
    logic [`MMP_RAM_BYTES-1:0][`MMP_DATA_W-1:0] mem_d;

    // One write-enabled latch byte per location
    for (genvar i = 0; i < `MMP_RAM_BYTES; i++) begin : g_byte
        assign mem_d[i] = (cb.ram_wr && cb.ram_idx == 8'(i)) ? cb.wdata : s_reg.mem[i];
    end

    always_comb begin
        s_next = s_reg;
        s_next.mem = mem_d;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            s_reg <= {`MMP_RAM_BYTES{`MMP_RAM_RST}};
        end else begin
            s_reg <= s_next;
        end
    end

    // Index guard keeps an out-of-range index from reading X
    assign cb.ram_rdata = (cb.ram_idx < 8'(`MMP_RAM_BYTES)) ? s_reg.mem[cb.ram_idx] : `MMP_UNMAPPED_RD;

    ram_byte_store_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cb.ram_wr |=> s_reg.mem[$past(cb.ram_idx)] == $past(cb.wdata))
        else $error("RAM byte not stored");
    ram_byte_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !cb.ram_wr |=> $stable(s_reg.mem))
        else $error("RAM changed without write");
endmodule : ram_bank

// file: rtl/io_port.sv
`include "mmport_cfg.svh"

module io_port (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [`MMP_DATA_W-1:0] in_pins_i,
    output logic [`MMP_DATA_W-1:0] out_pins_o,
    cell_bus_if.port cb
);
    mmport_pkg::port_state_t s_reg;
    mmport_pkg::port_state_t s_next;

    always_comb begin
        s_next = s_reg;
        // Pins are asynchronous: two flops before the bus sees them
        s_next.in_meta = in_pins_i;
        s_next.in_sync = s_reg.in_meta;
        if (cb.out_wr) begin
            s_next.out_latch = cb.wdata;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            s_reg <= '{in_meta: '0, in_sync: '0, out_latch: `MMP_OUT_PORT_RST};
        end else begin
            s_reg <= s_next;
        end
    end

    assign out_pins_o = s_reg.out_latch;
    assign cb.out_q = s_reg.out_latch;
    assign cb.in_q = s_reg.in_sync;

    out_latch_load_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cb.out_wr |=> out_pins_o == $past(cb.wdata))
        else $error("Output latch missed write");
    out_latch_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !cb.out_wr |=> $stable(out_pins_o))
        else $error("Output pins moved without write");
endmodule : io_port

// file: rtl/memory_mapped_port_bits.sv
// How it works
// - A write to a RAM byte stores it; it holds until rewritten.
// - A read of a RAM byte returns the stored value through the read mux.
// - A read of the input port returns the synchronised pin levels.
// - A write to the input port changes nothing.
// - A write to the output port latches data and drives it on the pins.
// - A read of the output port returns the latch, not the pin levels.
// - Every location and port is one byte; the bit cell repeats eight times.
// - Thirteen address lines decode 8192 locations, zero first, all ones last.
// - Direct addressing reaches the first 256 locations with upper byte zero.
// - All I/O and the 176 RAM bytes decode inside the first 256 locations.
// - Bus clock is the core clock divided by two.
// - Every read or write completes within one bus clock cycle.
`include "mmport_cfg.svh"

module memory_mapped_port_bits (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic [`MMP_ADDR_W-1:0] addr_i,
    input wire logic [`MMP_DATA_W-1:0] wdata_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [`MMP_DATA_W-1:0] in_pins_i,
    output logic [`MMP_DATA_W-1:0] rdata_o,
    output logic rd_ack_o,
    output logic bus_clk_o,
    output logic [`MMP_DATA_W-1:0] out_pins_o
);
    mmport_pkg::top_state_t s_reg;
    mmport_pkg::top_state_t s_next;
    mmport_pkg::region_t region;
    cell_bus_if cb ();

    logic page_zero;
    logic take;
    logic rd_take;
    logic wr_take;
    logic [`MMP_DATA_W-1:0] rd_mux;

    // Address decode
    always_comb begin
        // Direct page: upper address bits must be zero
        page_zero = (addr_i[`MMP_ADDR_W-1:`MMP_PAGE_HI_LSB] == '0);
        region = mmport_pkg::RGN_NONE;
        if (page_zero) begin
            if (addr_i == `MMP_OUT_PORT_OFS) begin
                region = mmport_pkg::RGN_OUT;
            end else if (addr_i == `MMP_IN_PORT_OFS) begin
                region = mmport_pkg::RGN_IN;
            end else if (addr_i >= `MMP_RAM_BASE) begin
                region = mmport_pkg::RGN_RAM;
            end
        end
    end

    // Requests are taken once per bus cycle, at its second half
    always_comb begin
        take = (s_reg.phase == mmport_pkg::PH_SECOND);
        // A read wins if the core raises both strobes
        rd_take = take && rd_i;
        wr_take = take && wr_i && !rd_i;
    end

    // Strobes reach only the addressed cells
    always_comb begin
        cb.wdata = wdata_i;
        cb.ram_idx = 8'(addr_i - `MMP_RAM_BASE);
        cb.ram_wr = wr_take && (region == mmport_pkg::RGN_RAM);
        cb.out_wr = wr_take && (region == mmport_pkg::RGN_OUT);
        // RGN_IN has no write strobe at all
    end

    // Read-enabled mux onto the data bus
    always_comb begin
        unique case (region)
            mmport_pkg::RGN_RAM: rd_mux = cb.ram_rdata;
            mmport_pkg::RGN_IN: rd_mux = cb.in_q;
            mmport_pkg::RGN_OUT: rd_mux = cb.out_q;
            mmport_pkg::RGN_NONE: rd_mux = `MMP_UNMAPPED_RD;
        endcase
    end

    always_comb begin
        s_next = s_reg;
        // Divide by two
        unique case (s_reg.phase)
            mmport_pkg::PH_FIRST: s_next.phase = mmport_pkg::PH_SECOND;
            mmport_pkg::PH_SECOND: s_next.phase = mmport_pkg::PH_FIRST;
        endcase
        s_next.bus_clk = (s_next.phase == mmport_pkg::PH_SECOND);
        s_next.rd_ack = rd_take;
        // Last read data stays on the bus until the next read
        if (rd_take) begin
            s_next.rdata = rd_mux;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            s_reg <= '{phase: mmport_pkg::PH_FIRST, bus_clk: 1'b0, rd_ack: 1'b0, rdata: `MMP_UNMAPPED_RD};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_o = s_reg.rdata;
    assign rd_ack_o = s_reg.rd_ack;
    assign bus_clk_o = s_reg.bus_clk;

    ram_bank u_ram (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .cb(cb.ram)
    );

    io_port u_port (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .in_pins_i(in_pins_i),
        .out_pins_o(out_pins_o),
        .cb(cb.port)
    );

    // Helper: ticks since last read acknowledge, saturating
    logic [7:0] since_ack;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || rd_ack_o) begin
            since_ack <= 8'h00;
        end else if (since_ack != 8'hFF) begin
            since_ack <= since_ack + 8'h01;
        end
    end

    // Helper: cycles a request has waited untaken, saturating
    logic [7:0] req_age;
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i || !(rd_i || wr_i) || take) begin
            req_age <= 8'h00;
        end else if (req_age != 8'hFF) begin
            req_age <= req_age + 8'h01;
        end
    end

    ram_read_path_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take && region == mmport_pkg::RGN_RAM
        |=> rd_ack_o && rdata_o == $past(cb.ram_rdata))
        else $error("RAM read returned wrong byte");

    in_read_path_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_i && addr_i == `MMP_IN_PORT_OFS && take
        |=> rdata_o == $past(in_pins_i, 3))
        else $error("Input port read mismatch");

    in_write_ignored_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_i && !rd_i && addr_i == `MMP_IN_PORT_OFS
        |-> !cb.ram_wr && !cb.out_wr ##1 $stable(out_pins_o))
        else $error("Input port write had an effect");

    out_readback_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take && addr_i == `MMP_OUT_PORT_OFS
        |=> rdata_o == $past(out_pins_o))
        else $error("Output readback not from latch");

    out_write_drive_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_take && addr_i == `MMP_OUT_PORT_OFS
        |=> out_pins_o == $past(wdata_i) ##1 out_pins_o == $past(wdata_i, 2) || cb.out_wr)
        else $error("Output port not driven by write");

    last_loc_unmapped_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take && addr_i == 13'h1FFF
        |=> rdata_o == `MMP_UNMAPPED_RD)
        else $error("Top location decoded as a cell");

    high_page_quiet_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        addr_i[`MMP_ADDR_W-1:`MMP_PAGE_HI_LSB] != '0
        |-> !cb.ram_wr && !cb.out_wr && region == mmport_pkg::RGN_NONE)
        else $error("Strobe outside first page");

    ram_window_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        cb.ram_wr |-> addr_i >= `MMP_RAM_BASE && addr_i <= 13'h00FF && cb.ram_idx < 8'(`MMP_RAM_BYTES))
        else $error("RAM strobe outside its window");

    strobe_one_hot_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !(cb.ram_wr && cb.out_wr)
        && (!(cb.ram_wr || cb.out_wr) || (wr_i && take)))
        else $error("Stray write strobe");

    bus_clk_div_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        bus_clk_o |=> !bus_clk_o ##1 bus_clk_o)
        else $error("Bus clock not core divided by two");

    read_done_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_i ##1 rd_i |=> rd_ack_o || $past(rd_ack_o))
        else $error("Read not done within one bus cycle");

    ack_spacing_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_ack_o |-> ##1 !rd_ack_o ##1 since_ack == 8'h01)
        else $error("Read acknowledges closer than a bus cycle");

    ack_budget_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_i
        |-> ##[1:2] rd_ack_o)
        else $error("Read exceeded bus cycle budget");

    ram_no_out_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        region == mmport_pkg::RGN_RAM
        |-> !cb.out_wr)
        else $error("Output strobe on a RAM address");

    ack_after_take_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take
        |=> rd_ack_o)
        else $error("Taken read not acknowledged");

    ack_from_take_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_ack_o
        |-> $past(rd_take))
        else $error("Acknowledge without a taken read");

    rdata_hold_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !rd_ack_o
        |-> $stable(rdata_o))
        else $error("Read data moved without acknowledge");

    in_no_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        region == mmport_pkg::RGN_IN
        |-> !cb.ram_wr && !cb.out_wr)
        else $error("Strobe on the input port address");

    req_budget_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_i || wr_i
        |-> req_age < 8'(`MMP_BUS_CYC_MAX_CYC))
        else $error("Request waited past the bus cycle");

    first_loc_out_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        addr_i == 13'h0000
        |-> region == mmport_pkg::RGN_OUT)
        else $error("First location not the output port");

    ram_first_byte_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        addr_i == `MMP_RAM_BASE
        |-> region == mmport_pkg::RGN_RAM && cb.ram_idx == 8'h00)
        else $error("RAM base not RAM byte zero");

    ram_last_byte_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        addr_i == 13'h00FF
        |-> region == mmport_pkg::RGN_RAM && cb.ram_idx == 8'(`MMP_RAM_BYTES - 1))
        else $error("Page end not the last RAM byte");

    gap_unmapped_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        page_zero && addr_i > `MMP_IN_PORT_OFS && addr_i < `MMP_RAM_BASE
        |-> region == mmport_pkg::RGN_NONE)
        else $error("Gap address decoded as a cell");

    write_no_ack_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_take
        |=> !rd_ack_o)
        else $error("Write raised read acknowledge");

    read_keeps_pins_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take
        |=> $stable(out_pins_o))
        else $error("Read moved the output pins");

    in_sync_path_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take && region == mmport_pkg::RGN_IN
        |=> rd_ack_o && rdata_o == $past(cb.in_q))
        else $error("Input read not from synchroniser");

    none_read_zero_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take && region == mmport_pkg::RGN_NONE
        |=> rdata_o == `MMP_UNMAPPED_RD)
        else $error("Unmapped read not idle value");

    strobe_bus_phase_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !bus_clk_o
        |-> !cb.ram_wr && !cb.out_wr)
        else $error("Write strobe in low bus clock half");

    ram_idx_range_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        region == mmport_pkg::RGN_RAM
        |-> cb.ram_idx < 8'(`MMP_RAM_BYTES))
        else $error("RAM index out of range");

    ack_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_ack_o
        |=> !rd_ack_o)
        else $error("Read acknowledge longer than a cycle");

    read_no_write_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        rd_take
        |-> !cb.ram_wr && !cb.out_wr)
        else $error("Write strobe during a read");

    out_write_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_take && region == mmport_pkg::RGN_OUT
        |-> cb.out_wr && !cb.ram_wr)
        else $error("Output write not strobed");

    ram_write_strobe_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        wr_take && region == mmport_pkg::RGN_RAM
        |-> cb.ram_wr && !cb.out_wr)
        else $error("RAM write not strobed");
endmodule : memory_mapped_port_bits

// file: bench/cpu_bus_model.sv
`include "mmport_cfg.svh"

module cpu_bus_model (
    input wire logic core_clk_i,
    input wire logic bus_clk_i,
    input wire logic rd_ack_i,
    input wire logic [`MMP_DATA_W-1:0] rdata_i,
    output logic [`MMP_ADDR_W-1:0] addr_o,
    output logic [`MMP_DATA_W-1:0] wdata_o,
    output logic rd_o,
    output logic wr_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        addr_o = '0;
        wdata_o = '0;
        rd_o = 1'b0;
        wr_o = 1'b0;
    end

    // Entered just after a rising edge; one request every second bus cycle
    task automatic access(input logic is_rd, input logic [`MMP_ADDR_W-1:0] a, input logic [`MMP_DATA_W-1:0] d,
        output logic [`MMP_DATA_W-1:0] q, output logic ok, output logic hung);
        int n;
        n = 0;
        // One edge first, so a new request never lands in the step of the last release
        @(posedge core_clk_i);
        #1;
        // Raise in the low half, hold through the taking edge
        while (bus_clk_i !== 1'b0 && n < 4) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        hung = (n >= 4);
        addr_o = a;
        wdata_o = d;
        rd_o = is_rd;
        wr_o = !is_rd;
        repeat (2) @(posedge core_clk_i);
        #1;
        q = rdata_i;
        ok = (rd_ack_i === is_rd);
        rd_o = 1'b0;
        wr_o = 1'b0;
        // Released lines show the inverse so stale values never pass
        addr_o = ~a;
        wdata_o = ~d;
    endtask : access
endmodule : cpu_bus_model

// file: bench/memory_mapped_port_bits_tb.sv
`include "mmport_cfg.svh"

module memory_mapped_port_bits_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [`MMP_ADDR_W-1:0] addr;
    logic [`MMP_DATA_W-1:0] wdata;
    logic rd;
    logic wr;
    logic [`MMP_DATA_W-1:0] in_pins = 8'h00;
    logic [`MMP_DATA_W-1:0] rdata;
    logic rd_ack;
    logic bus_clk;
    logic [`MMP_DATA_W-1:0] out_pins;
    int fail_count = 0;
    int check_count = 0;
    logic [`MMP_ADDR_W-1:0] ram_addr [4] = '{13'h0050, 13'h0051, 13'h00A7, 13'h00FF};
    logic [`MMP_ADDR_W-1:0] bad_addr [5] = '{13'h0002, 13'h004F, 13'h0150, 13'h1F50, 13'h1FFF};

    always #4 core_clk = ~core_clk;

    memory_mapped_port_bits memory_mapped_port_bits_inst (
        .core_clk_i(core_clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata), .rd_i(rd), .wr_i(wr),
        .in_pins_i(in_pins), .rdata_o(rdata), .rd_ack_o(rd_ack), .bus_clk_o(bus_clk), .out_pins_o(out_pins)
    );

    cpu_bus_model cpu_bus_model_inst (
        .core_clk_i(core_clk), .bus_clk_i(bus_clk), .rd_ack_i(rd_ack), .rdata_i(rdata),
        .addr_o(addr), .wdata_o(wdata), .rd_o(rd), .wr_o(wr)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic xfer(input logic is_rd, input logic [12:0] a, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] q;
        logic ok;
        logic hung;
        cpu_bus_model_inst.access(is_rd, a, d, q, ok, hung);
        if (hung) begin
            fail_count++;
            end_of_test();
        end else begin
            check("ack after one bus cycle", 8'h01, {7'h00, ok});
            if (is_rd) begin
                check("read data", exp, q);
            end
        end
    endtask : xfer

    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        check("reset out pins", 8'h00, out_pins);
        rstn = 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            #1;
            check("bus clock", {7'h00, ~i[0]}, {7'h00, bus_clk});
        end
        xfer(1'b1, 13'h0000, 8'h00, 8'h00);
        xfer(1'b1, 13'h0050, 8'h00, 8'h00);
        $display("test reset values done");
        in_pins = 8'h3C;
        xfer(1'b0, 13'h0000, 8'hA5, 8'h00);
        check("out pins", 8'hA5, out_pins);
        in_pins = 8'hC3;
        xfer(1'b1, 13'h0000, 8'h00, 8'hA5);
        xfer(1'b1, 13'h0001, 8'h00, 8'hC3);
        xfer(1'b0, 13'h0001, 8'h81, 8'h00);
        check("out pins", 8'hA5, out_pins);
        xfer(1'b1, 13'h0001, 8'h00, 8'hC3);
        $display("test ports done");
        // Back to back writes, then readback of every edge of the RAM range
        foreach (ram_addr[i]) xfer(1'b0, ram_addr[i], ram_addr[i][7:0] ^ 8'h5A, 8'h00);
        foreach (ram_addr[i]) xfer(1'b1, ram_addr[i], 8'h00, ram_addr[i][7:0] ^ 8'h5A);
        xfer(1'b0, 13'h0050, 8'hFF, 8'h00);
        xfer(1'b1, 13'h0051, 8'h00, 8'h51 ^ 8'h5A);
        $display("test ram done");
        foreach (bad_addr[i]) xfer(1'b0, bad_addr[i], 8'hEE, 8'h00);
        foreach (bad_addr[i]) xfer(1'b1, bad_addr[i], 8'h00, 8'h00);
        xfer(1'b1, 13'h0050, 8'h00, 8'hFF);
        xfer(1'b1, 13'h00FF, 8'h00, 8'hFF ^ 8'h5A);
        check("out pins", 8'hA5, out_pins);
        $display("test unmapped done");
        // Reset in mid-run clears latch and RAM
        rstn = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check("reset out pins", 8'h00, out_pins);
        rstn = 1'b1;
        xfer(1'b1, 13'h00A7, 8'h00, 8'h00);
        $display("test second reset done");
        end_of_test();
    end
endmodule : memory_mapped_port_bits_tb
